// [rtl/intc_pkg.sv]
// Constants, register map and types of the interrupt acceptance controller
package intc_pkg;
	localparam int NSRC = 25;
	localparam int SRCW = 5;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL_FIRST = 8'h00;
	localparam logic [7:0] OFF_CTRL_LAST = 8'h60;
	localparam logic [7:0] OFF_MASK_LOW = 8'h80;
	localparam logic [7:0] OFF_MASK_HIGH = 8'h84;
	localparam logic [7:0] OFF_ISR = 8'h88;
	localparam logic [7:0] OFF_NEST = 8'h8c;
	localparam logic [7:0] OFF_WDM = 8'h90;
	// Per-source control register fields
	localparam int CTL_PEND = 0;
	localparam int CTL_MASK = 1;
	localparam int CTL_MACRO = 2;
	localparam int CTL_CSW = 3;
	localparam int CTL_LVL = 4;
	// Record fields: bits 3..0 levels, 4 pin NMI, 5 watchdog NMI
	localparam int ISR_NMI_PIN = 4;
	localparam int ISR_NMI_WDT = 5;
	localparam int MASK_LOW_BITS = 16;
	localparam int MASK_HIGH_BITS = 9;
	// Reset values
	localparam logic [1:0] LVL_RESET = 2'h3;
	localparam logic [1:0] LVL_LOWEST = 2'h3;
	localparam logic [2:0] LVL_NONE = 3'h4;
	localparam logic [NSRC-1:0] MASK_RESET = 25'h1ffffff;
	// Sources 14 and 18 cannot use macro service
	localparam logic [NSRC-1:0] MACRO_CAPABLE = 25'h1fbbfff;
	// Vector table addresses
	localparam logic [15:0] VEC_NMI_PIN = 16'h0002;
	localparam logic [15:0] VEC_NMI_WDT = 16'h0004;
	localparam logic [15:0] VEC_MASK_BASE = 16'h0006;
	localparam logic [15:0] VEC_OPERR = 16'h003c;
	localparam logic [15:0] VEC_BRK = 16'h003e;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		S_IDLE = 2'b01,
		S_OFFER = 2'b10
	} ctl_state_e;
	typedef enum logic [2:0] {
		K_NMI_PIN = 3'h0,
		K_NMI_WDT = 3'h1,
		K_OPERR = 3'h2,
		K_BRK = 3'h3,
		K_BRK_BANK = 3'h4,
		K_MACRO = 3'h5,
		K_VECT = 3'h6,
		K_CSW = 3'h7
	} ack_kind_e;
endpackage : intc_pkg

// [rtl/interrupt_acceptance_control.sv]
// Interrupt acceptance and service-mode control with AXI4-Lite registers
//
// Function
// - Both break instructions bypass enable and priority
// - Illegal immediate operand raises operand error interrupt
// - Operand errors bypass enable flag and priority
// - Non-maskable from pin or watchdog overflow
// - Non-maskable bypasses control, ranks above all
// - Hold non-maskable while same/higher one serviced
// - Per-source mask blocks acknowledgment
// - Global enable gates vectored and context-switch acknowledgment
// - Same level resolved by fixed default order
// - Four programmable priority levels per source
// - Macro service ignores enable and level
// - Vectored: stack save, jump via vector
// - Macro: suspend, transfer, no state save
// - Context switch: bank select, save, branch
// - Three modes; some sources lack macro
// - Two grouped masks mirror flags, byte access
// - Record levels of interrupts in service
// - Control bit allows level 3 nesting
// - Watchdog mode picks NMI pin/watchdog order
// - Per-source control register with all fields
// - Level 0 highest, larger numbers lower
// - Reset sets all levels to lowest
module interrupt_acceptance_control
	import intc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Request sources
	input wire logic [NSRC-1:0] src_req,
	input wire logic nmi_pin,
	input wire logic wdt_overflow,
	input wire logic brk_vector,
	input wire logic brk_bank,
	input wire logic opnd_err_standby,
	input wire logic opnd_err_watchdog,
	input wire logic opnd_err_placement,
	// CPU core
	input wire logic psw_global_enable,
	input wire logic svc_retire,
	output logic ack_valid,
	input wire logic ack_ready,
	output logic [2:0] ack_kind,
	output logic [SRCW-1:0] ack_src,
	output logic [1:0] ack_level,
	output logic [15:0] ack_vector,
	output logic stack_save,
	output logic bank_switch,
	output logic macro_suspend
);

	typedef struct packed {
		ctl_state_e state;
		logic [NSRC-1:0] pend;
		logic [NSRC-1:0] mask;
		logic [NSRC-1:0] macro;
		logic [NSRC-1:0] csw;
		logic [NSRC-1:0][1:0] lvl;
		logic [5:0] isr;
		logic nest;
		logic wdt_first;
		logic nmi_s1;
		logic nmi_s2;
		logic nmi_s3;
		logic nmi_pin_pend;
		logic nmi_wdt_pend;
		logic operr_pend;
		logic brk_pend;
		logic brk_bank_pend;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic ack_valid;
		ack_kind_e ack_kind;
		logic [SRCW-1:0] ack_src;
		logic [1:0] ack_level;
		logic [15:0] ack_vector;
		logic stack_save;
		logic bank_switch;
		logic macro_suspend;
	} state_s;

	state_s q, n;
	logic [2:0] cur_top;
	logic nmi_pin_ok, nmi_wdt_ok, nmi_go, sw_go;
	logic mac_found, msk_found;
	logic [SRCW-1:0] mac_idx, msk_idx;
	logic [1:0] msk_lvl;
	logic [NSRC-1:0] mac_cand, msk_cand;

	// Candidate sets per source
	for (genvar i = 0; i < NSRC; i++) begin : g_cand
		always_comb begin
			mac_cand[i] = q.pend[i] && !q.mask[i] && q.macro[i]
				&& MACRO_CAPABLE[i];
			msk_cand[i] = q.pend[i] && !q.mask[i] && psw_global_enable
				&& !(q.macro[i] && MACRO_CAPABLE[i])
				&& ({1'b0, q.lvl[i]} < cur_top
				|| (q.nest && q.lvl[i] == LVL_LOWEST
				&& cur_top == {1'b0, LVL_LOWEST}));
		end
	end

	always_comb begin
		logic [7:0] rd_off;
		rd_off = araddr;
		n = q;
		// Highest level now in service
		cur_top = LVL_NONE;
		for (int l = 3; l >= 0; l--) begin
			if (q.isr[l]) begin
				cur_top = 3'(l);
			end
		end
		// Non-maskable hold-off and order
		nmi_pin_ok = q.nmi_pin_pend && !q.isr[ISR_NMI_PIN]
			&& !(q.wdt_first && q.isr[ISR_NMI_WDT]);
		nmi_wdt_ok = q.nmi_wdt_pend && !q.isr[ISR_NMI_WDT]
			&& !(!q.wdt_first && q.isr[ISR_NMI_PIN]);
		nmi_go = nmi_pin_ok || nmi_wdt_ok;
		sw_go = q.brk_pend || q.brk_bank_pend;
		// Macro in default order; maskable by level then default order
		mac_found = 1'b0;
		mac_idx = '0;
		msk_found = 1'b0;
		msk_idx = '0;
		msk_lvl = LVL_LOWEST;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (mac_cand[i]) begin
				mac_found = 1'b1;
				mac_idx = SRCW'(i);
			end
		end
		for (int i = 0; i < NSRC; i++) begin
			if (msk_cand[i] && (!msk_found || q.lvl[i] < msk_lvl)) begin
				msk_found = 1'b1;
				msk_idx = SRCW'(i);
				msk_lvl = q.lvl[i];
			end
		end

		// Synchroniser and edge of the pin
		n.nmi_s1 = nmi_pin;
		n.nmi_s2 = q.nmi_s1;
		n.nmi_s3 = q.nmi_s2;

		// Register writes
		if (q.aw_got && q.w_got && !q.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			if (q.aw_addr <= OFF_CTRL_LAST && q.aw_addr[1:0] == 2'h0) begin
				if (q.w_strb[0]) begin
					n.pend[q.aw_addr[6:2]] = q.w_data[CTL_PEND];
					n.mask[q.aw_addr[6:2]] = q.w_data[CTL_MASK];
					n.macro[q.aw_addr[6:2]] = q.w_data[CTL_MACRO];
					n.csw[q.aw_addr[6:2]] = q.w_data[CTL_CSW];
					n.lvl[q.aw_addr[6:2]] = q.w_data[CTL_LVL+:2];
				end
			end else if (q.aw_addr == OFF_MASK_LOW) begin
				for (int b = 0; b < MASK_LOW_BITS; b++) begin
					if (q.w_strb[b/8]) begin
						n.mask[b] = q.w_data[b];
					end
				end
			end else if (q.aw_addr == OFF_MASK_HIGH) begin
				for (int b = 0; b < MASK_HIGH_BITS; b++) begin
					if (q.w_strb[b/8]) begin
						n.mask[MASK_LOW_BITS+b] = q.w_data[b];
					end
				end
			end else if (q.aw_addr == OFF_NEST) begin
				if (q.w_strb[0]) begin
					n.nest = q.w_data[0];
				end
			end else if (q.aw_addr == OFF_WDM) begin
				if (q.w_strb[0]) begin
					n.wdt_first = q.w_data[0];
				end
			end else if (q.aw_addr != OFF_ISR) begin
				n.bresp = RESP_SLVERR;
			end
		end
		if (q.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		if (awvalid && q.awready) begin
			n.aw_got = 1'b1;
			n.aw_addr = awaddr;
		end
		if (wvalid && q.wready) begin
			n.w_got = 1'b1;
			n.w_data = wdata;
			n.w_strb = wstrb;
		end

		// Register reads
		if (q.rvalid && rready) begin
			n.rvalid = 1'b0;
		end
		if (arvalid && q.arready) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = '0;
			if (rd_off <= OFF_CTRL_LAST && rd_off[1:0] == 2'h0) begin
				n.rdata[CTL_PEND] = q.pend[rd_off[6:2]];
				n.rdata[CTL_MASK] = q.mask[rd_off[6:2]];
				n.rdata[CTL_MACRO] = q.macro[rd_off[6:2]];
				n.rdata[CTL_CSW] = q.csw[rd_off[6:2]];
				n.rdata[CTL_LVL+:2] = q.lvl[rd_off[6:2]];
			end else if (rd_off == OFF_MASK_LOW) begin
				n.rdata[MASK_LOW_BITS-1:0] = q.mask[MASK_LOW_BITS-1:0];
			end else if (rd_off == OFF_MASK_HIGH) begin
				n.rdata[MASK_HIGH_BITS-1:0] = q.mask[NSRC-1:MASK_LOW_BITS];
			end else if (rd_off == OFF_ISR) begin
				n.rdata[5:0] = q.isr;
			end else if (rd_off == OFF_NEST) begin
				n.rdata[0] = q.nest;
			end else if (rd_off == OFF_WDM) begin
				n.rdata[0] = q.wdt_first;
			end else begin
				n.rresp = RESP_SLVERR;
			end
		end

		// End of a recorded service routine clears its record
		if (svc_retire) begin
			if (q.isr[ISR_NMI_PIN] && (!q.wdt_first || !q.isr[ISR_NMI_WDT])) begin
				n.isr[ISR_NMI_PIN] = 1'b0;
			end else if (q.isr[ISR_NMI_WDT]) begin
				n.isr[ISR_NMI_WDT] = 1'b0;
			end else if (cur_top != LVL_NONE) begin
				n.isr[cur_top[1:0]] = 1'b0;
			end
		end

		// Acceptance and offer to the CPU
		unique case (q.state)
			S_IDLE: begin
				n.stack_save = 1'b0;
				n.bank_switch = 1'b0;
				n.macro_suspend = 1'b0;
				n.ack_src = '0;
				n.ack_level = '0;
				if (nmi_go) begin
					n.state = S_OFFER;
					n.ack_valid = 1'b1;
					n.stack_save = 1'b1;
					if (nmi_pin_ok && (!nmi_wdt_ok || !q.wdt_first)) begin
						n.ack_kind = K_NMI_PIN;
						n.ack_vector = VEC_NMI_PIN;
						n.nmi_pin_pend = 1'b0;
						n.isr[ISR_NMI_PIN] = 1'b1;
					end else begin
						n.ack_kind = K_NMI_WDT;
						n.ack_vector = VEC_NMI_WDT;
						n.nmi_wdt_pend = 1'b0;
						n.isr[ISR_NMI_WDT] = 1'b1;
					end
				end else if (q.operr_pend) begin
					n.state = S_OFFER;
					n.ack_valid = 1'b1;
					n.ack_kind = K_OPERR;
					n.ack_vector = VEC_OPERR;
					n.stack_save = 1'b1;
					n.operr_pend = 1'b0;
				end else if (sw_go) begin
					n.state = S_OFFER;
					n.ack_valid = 1'b1;
					if (q.brk_pend) begin
						n.ack_kind = K_BRK;
						n.ack_vector = VEC_BRK;
						n.stack_save = 1'b1;
						n.brk_pend = 1'b0;
					end else begin
						n.ack_kind = K_BRK_BANK;
						n.ack_vector = '0;
						n.bank_switch = 1'b1;
						n.brk_bank_pend = 1'b0;
					end
				end else if (mac_found) begin
					n.state = S_OFFER;
					n.ack_valid = 1'b1;
					n.ack_kind = K_MACRO;
					n.ack_src = mac_idx;
					n.ack_level = q.lvl[mac_idx];
					n.ack_vector = '0;
					n.macro_suspend = 1'b1;
					n.pend[mac_idx] = 1'b0;
				end else if (msk_found) begin
					n.state = S_OFFER;
					n.ack_valid = 1'b1;
					n.ack_src = msk_idx;
					n.ack_level = msk_lvl;
					n.pend[msk_idx] = 1'b0;
					n.isr[msk_lvl] = 1'b1;
					if (q.csw[msk_idx]) begin
						n.ack_kind = K_CSW;
						n.ack_vector = '0;
						n.bank_switch = 1'b1;
					end else begin
						n.ack_kind = K_VECT;
						n.ack_vector = VEC_MASK_BASE + 16'({msk_idx, 1'b0});
						n.stack_save = 1'b1;
					end
				end
			end
			S_OFFER: begin
				if (ack_ready) begin
					n.state = S_IDLE;
					n.ack_valid = 1'b0;
				end
			end
		endcase

		// Hardware sets win over any clear in the same cycle
		n.pend = n.pend | src_req;
		if (q.nmi_s2 && !q.nmi_s3) begin
			n.nmi_pin_pend = 1'b1;
		end
		if (wdt_overflow) begin
			n.nmi_wdt_pend = 1'b1;
		end
		if (opnd_err_standby || opnd_err_watchdog || opnd_err_placement) begin
			n.operr_pend = 1'b1;
		end
		if (brk_vector) begin
			n.brk_pend = 1'b1;
		end
		if (brk_bank) begin
			n.brk_bank_pend = 1'b1;
		end
		n.awready = !n.aw_got;
		n.wready = !n.w_got;
		n.arready = !n.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.state <= S_IDLE;
			q.mask <= MASK_RESET;
			q.lvl <= {NSRC{LVL_RESET}};
			q.ack_kind <= K_NMI_PIN;
		end else begin
			q <= n;
		end
	end

	assign awready = q.awready;
	assign wready = q.wready;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = q.arready;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign ack_valid = q.ack_valid;
	assign ack_kind = q.ack_kind;
	assign ack_src = q.ack_src;
	assign ack_level = q.ack_level;
	assign ack_vector = q.ack_vector;
	assign stack_save = q.stack_save;
	assign bank_switch = q.bank_switch;
	assign macro_suspend = q.macro_suspend;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	nmi_first_a: assert property (q.state == S_IDLE && nmi_go
		|=> ack_valid && (ack_kind == K_NMI_PIN || ack_kind == K_NMI_WDT))
		else $error("pending NMI not taken first");
	nmi_hold_a: assert property ($rose(ack_valid) && ack_kind == K_NMI_PIN
		|-> !$past(q.isr[ISR_NMI_PIN]))
		else $error("pin NMI taken while in service");
	operr_raise_a: assert property (opnd_err_placement
		|=> q.operr_pend || (ack_valid && ack_kind == K_OPERR))
		else $error("operand error lost");
	sw_take_a: assert property (q.state == S_IDLE && sw_go && !nmi_go
		&& !q.operr_pend && !psw_global_enable
		|=> ack_kind == K_BRK || ack_kind == K_BRK_BANK)
		else $error("break not taken while disabled");
	mask_block_a: assert property ($rose(ack_valid)
		&& (ack_kind == K_VECT || ack_kind == K_CSW || ack_kind == K_MACRO)
		|-> ($past(q.mask) & (NSRC'(1) << ack_src)) == '0)
		else $error("masked source acknowledged");
	global_en_a: assert property ($rose(ack_valid)
		&& (ack_kind == K_VECT || ack_kind == K_CSW)
		|-> $past(psw_global_enable))
		else $error("maskable taken while disabled");
	level_rank_a: assert property ($rose(ack_valid) && ack_kind == K_VECT
		|-> {1'b0, ack_level} < $past(cur_top)
		|| ($past(q.nest) && ack_level == LVL_LOWEST))
		else $error("level not above in-service level");
	macro_free_a: assert property (q.state == S_IDLE && mac_found && !nmi_go
		&& !q.operr_pend && !sw_go |=> ack_kind == K_MACRO ##0 macro_suspend)
		else $error("macro request not taken");
	macro_mode_a: assert property (ack_valid && macro_suspend
		|-> !stack_save && !bank_switch && MACRO_CAPABLE[ack_src])
		else $error("macro service saved state");
	reset_level_a: assert property (!$past(aresetn)
		|-> q.lvl == {NSRC{LVL_RESET}})
		else $error("levels not lowest after reset");

	nmi_ack_c: cover property (ack_valid && ack_kind == K_NMI_WDT);
	macro_ack_c: cover property (ack_valid && ack_kind == K_MACRO);
	csw_ack_c: cover property (ack_valid && ack_kind == K_CSW);
	nested_c: cover property (q.isr[0] && q.isr[3]);

endmodule : interrupt_acceptance_control

// [tb/cpu_model.sv]
// CPU-side model that takes interrupt offers after a chosen delay
module cpu_model
	import intc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Offer from the controller
	input wire logic ack_valid,
	input wire logic [2:0] ack_kind,
	input wire logic [SRCW-1:0] ack_src,
	input wire logic [1:0] ack_level,
	input wire logic [15:0] ack_vector,
	input wire logic stack_save,
	input wire logic bank_switch,
	input wire logic macro_suspend,
	// Bench control and capture
	input wire logic [3:0] delay,
	output logic ack_ready,
	output logic [7:0] take_cnt,
	output logic [28:0] got_offer
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_ready <= 1'b0;
			take_cnt <= 8'h00;
			got_offer <= '0;
			wait_q <= 4'h0;
		end else if (ack_valid && ack_ready) begin
			ack_ready <= 1'b0;
			wait_q <= 4'h0;
			take_cnt <= take_cnt + 8'h01;
			got_offer <= {ack_kind, ack_src, ack_level, ack_vector,
				stack_save, bank_switch, macro_suspend};
		end else if (ack_valid) begin
			// Slow CPU holds ready low for delay plus one cycles
			wait_q <= wait_q + 4'h1;
			ack_ready <= (wait_q >= delay);
		end
	end
endmodule : cpu_model

// [tb/interrupt_acceptance_control_tb.sv]
// Self-checking testbench of the interrupt acceptance controller
module interrupt_acceptance_control_tb
	import intc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, nmi_pin = 1'b0, glob_en = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0, delay = 4'h0;
	logic [NSRC-1:0] src_req = '0;
	// Retire, watchdog, breaks, three operand errors
	logic [6:0] evt = 7'h00;
	logic awready, wready, bvalid, arready, rvalid, ack_valid, ack_ready;
	logic stack_save, bank_switch, macro_suspend;
	logic [1:0] bresp, rresp, ack_level;
	logic [31:0] rdata;
	logic [2:0] ack_kind;
	logic [SRCW-1:0] ack_src;
	logic [15:0] ack_vector;
	logic [7:0] take_cnt;
	logic [28:0] got_offer;
	int bad_count = 0;
	int cmp_count = 0;
	always #20 aclk = ~aclk;
	interrupt_acceptance_control interrupt_acceptance_control_inst (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.src_req(src_req), .nmi_pin(nmi_pin), .wdt_overflow(evt[5]),
		.brk_vector(evt[4]), .brk_bank(evt[3]),
		.opnd_err_standby(evt[2]), .opnd_err_watchdog(evt[1]),
		.opnd_err_placement(evt[0]), .psw_global_enable(glob_en),
		.svc_retire(evt[6]), .ack_valid(ack_valid), .ack_ready(ack_ready),
		.ack_kind(ack_kind), .ack_src(ack_src), .ack_level(ack_level),
		.ack_vector(ack_vector), .stack_save(stack_save),
		.bank_switch(bank_switch), .macro_suspend(macro_suspend)
	);
	cpu_model cpu_model_inst (
		.aclk(aclk), .aresetn(aresetn), .ack_valid(ack_valid),
		.ack_kind(ack_kind), .ack_src(ack_src), .ack_level(ack_level),
		.ack_vector(ack_vector), .stack_save(stack_save),
		.bank_switch(bank_switch), .macro_suspend(macro_suspend),
		.delay(delay), .ack_ready(ack_ready), .take_cnt(take_cnt),
		.got_offer(got_offer)
	);
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
			bad_count++;
		end
	endtask : check
	task automatic hang();
		$display("[FAIL] t=%0t got %h exp %h (timeout)", $time, 0, 1);
		bad_count++;
		final_report();
	endtask : hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY, input logic [3:0] ws = 4'h1);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= ws;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 50) hang();
		bready <= 1'b0;
		check(32'(bresp), 32'(er));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er = RESP_OKAY);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 50) hang();
		rready <= 1'b0;
		check(rdata, ed);
		check(32'(rresp), 32'(er));
	endtask : rd
	task automatic pulse(input logic [6:0] e, input logic [NSRC-1:0] r);
		@(posedge aclk);
		evt <= e;
		src_req <= r;
		@(posedge aclk);
		evt <= 7'h00;
		src_req <= '0;
	endtask : pulse
	function automatic logic [28:0] mk(input logic [2:0] k,
		input logic [4:0] s, input logic [1:0] l, input logic [15:0] v,
		input logic [2:0] f);
		return {k, s, l, v, f};
	endfunction : mk
	task automatic offer(input logic [28:0] e, input logic [28:0] m = '1);
		int n;
		logic [7:0] last;
		last = take_cnt;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (take_cnt !== last) break;
		end
		if (n == 40) hang();
		check(32'(got_offer & m), 32'(e & m));
	endtask : offer
	task automatic no_offer(input int c);
		logic seen;
		seen = 1'b0;
		repeat (c) begin
			@(posedge aclk);
			seen = seen | ack_valid;
		end
		check(32'(seen), 32'h0);
	endtask : no_offer
	task automatic t_reset();
		rd(OFF_CTRL_FIRST, 32'h32);
		rd(OFF_CTRL_LAST, 32'h32);
		rd(OFF_MASK_LOW, 32'hffff);
		rd(OFF_MASK_HIGH, 32'h1ff);
		wr(OFF_MASK_HIGH, 32'h0, RESP_OKAY, 4'h2);
		rd(OFF_MASK_HIGH, 32'hff);
		rd(OFF_CTRL_LAST, 32'h30);
		wr(OFF_MASK_HIGH, 32'h1ff, RESP_OKAY, 4'hf);
		rd(OFF_CTRL_LAST, 32'h32);
		rd(8'hfc, 32'h0, RESP_SLVERR);
		wr(OFF_ISR, 32'h3f);
		wr(8'h02, 32'h0, RESP_SLVERR);
		rd(OFF_ISR, 32'h0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_mask();
		wr(OFF_MASK_LOW, 32'hdf);
		rd(8'h14, 32'h30);
		pulse(7'h00, 25'h20);
		no_offer(10);
		glob_en <= 1'b1;
		offer(mk(K_VECT, 5, 2'h3, VEC_MASK_BASE + 16'ha, 3'b100));
		rd(OFF_ISR, 32'h8);
		pulse(7'h40, '0);
		wr(8'h14, 32'h02);
		rd(OFF_MASK_LOW, 32'hffff);
		pulse(7'h00, 25'h20);
		no_offer(8);
		wr(OFF_MASK_LOW, 32'hdf);
		offer(mk(K_VECT, 5, 2'h0, VEC_MASK_BASE + 16'ha, 3'b100));
		pulse(7'h40, '0);
		$display("mask test done");
	endtask : t_mask
	task automatic t_order();
		wr(8'h1c, 32'h20);
		wr(8'h24, 32'h20);
		wr(8'h30, 32'h10);
		pulse(7'h00, 25'h1280);
		offer(mk(K_VECT, 12, 2'h1, VEC_MASK_BASE + 16'h18, 3'b100));
		no_offer(8);
		pulse(7'h40, '0);
		offer(mk(K_VECT, 7, 2'h2, VEC_MASK_BASE + 16'he, 3'b100));
		no_offer(8);
		pulse(7'h40, '0);
		offer(mk(K_VECT, 9, 2'h2, VEC_MASK_BASE + 16'h12, 3'b100));
		pulse(7'h40, '0);
		wr(8'h50, 32'h30);
		wr(8'h54, 32'h30);
		pulse(7'h00, 25'h300000);
		offer(mk(K_VECT, 20, 2'h3, VEC_MASK_BASE + 16'h28, 3'b100));
		no_offer(8);
		wr(OFF_NEST, 32'h1);
		offer(mk(K_VECT, 21, 2'h3, VEC_MASK_BASE + 16'h2a, 3'b100));
		pulse(7'h40, '0);
		wr(OFF_NEST, 32'h0);
		$display("order test done");
	endtask : t_order
	task automatic t_modes();
		glob_en <= 1'b0;
		wr(8'h34, 32'h34);
		pulse(7'h00, 25'h2000);
		offer(mk(K_MACRO, 13, 2'h3, 16'h0, 3'b001));
		glob_en <= 1'b1;
		wr(8'h38, 32'h04);
		pulse(7'h00, 25'h4000);
		offer(mk(K_VECT, 14, 2'h0, VEC_MASK_BASE + 16'h1c, 3'b100));
		pulse(7'h40, '0);
		wr(8'h08, 32'h08);
		pulse(7'h00, 25'h4);
		offer(mk(K_CSW, 2, 2'h0, 16'h0, 3'b010), 29'h1ff80007);
		pulse(7'h40, '0);
		$display("mode test done");
	endtask : t_modes
	task automatic t_class();
		int i;
		delay <= 4'h3;
		glob_en <= 1'b0;
		pulse(7'h3f, '0);
		offer(mk(K_NMI_WDT, 0, 2'h0, VEC_NMI_WDT, 3'b100));
		offer(mk(K_OPERR, 0, 2'h0, VEC_OPERR, 3'b100));
		offer(mk(K_BRK, 0, 2'h0, VEC_BRK, 3'b100));
		offer(mk(K_BRK_BANK, 0, 2'h0, 16'h0, 3'b010));
		pulse(7'h40, '0);
		for (i = 0; i < 3; i++) begin
			pulse(7'(1 << i), '0);
			offer(mk(K_OPERR, 0, 2'h0, VEC_OPERR, 3'b100));
		end
		delay <= 4'h0;
		$display("class test done");
	endtask : t_class
	task automatic t_nmi();
		nmi_pin <= 1'b1;
		offer(mk(K_NMI_PIN, 0, 2'h0, VEC_NMI_PIN, 3'b100));
		pulse(7'h20, '0);
		no_offer(10);
		pulse(7'h40, '0);
		offer(mk(K_NMI_WDT, 0, 2'h0, VEC_NMI_WDT, 3'b100));
		pulse(7'h40, '0);
		nmi_pin <= 1'b0;
		wr(OFF_WDM, 32'h1);
		nmi_pin <= 1'b1;
		offer(mk(K_NMI_PIN, 0, 2'h0, VEC_NMI_PIN, 3'b100));
		pulse(7'h20, '0);
		offer(mk(K_NMI_WDT, 0, 2'h0, VEC_NMI_WDT, 3'b100));
		pulse(7'h40, '0);
		pulse(7'h40, '0);
		rd(OFF_ISR, 32'h0);
		$display("nmi test done");
	endtask : t_nmi
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_mask();
		t_order();
		t_modes();
		t_class();
		t_nmi();
		final_report();
	end
endmodule : interrupt_acceptance_control_tb
